// File: accumulator_lookup_tables.sv
// Purpose: lookup tables steering products into and out of the accumulator
// Assumes: host downloads bytes over Avalon-MM; datapath presents one lookup per cycle
// Notes:   three-cycle pipeline from request to answer on both ends
// Operation
// (RQ1) host sends aligned 256-byte blocks, padded
// (RQ2) back-end translates 11-bit result to another
// (RQ3) sixteen maps: normal, tape, pulsar
// (RQ4) map top bit selects validity accumulation table
// (RQ5) map low bit picks tape or pulsar
// (RQ6) result address is map, upper, low byte
// (RQ7) back-end high byte keeps three low bits
// (RQ8) low eleven address bits carry requested result
// (RQ9) host block runs from address 0 to 255
// (RQ10) front-end maps each product to accumulator result
// (RQ11) front-end high byte: three bits, inhibit on top
// (RQ12) inhibit gates master clear of accumulation time
// (RQ13) host sets inhibit only for later reductions
// (RQ14) front-end address: map, array, spectral result
// (RQ15) baseline table address: bank and baseline
// (RQ16) one global bank for five banked tables
// (RQ17) host keeps baseline translations in range
// (RQ18) baselines 213-215 real, 216-255 ignored
// (RQ19) accumulation map indexed by bank and baseline
// (RQ20) host loads one-to-one back-end maps
// (RQ21) entry holds accumulation high, mapping low nibble
// (RQ22) validity maps take accumulation from validity table
// (RQ23) tables written by host, read by datapath
// (RQ24) byte goes to selected table at start+index
`timescale 1ns/1ps
module accumulator_lookup_tables (
  input  wire logic               clock_i,
  input  wire logic               reset_n_i,
  input  wire logic [4:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  input  wire logic               interval_tick_i,
  input  wire logic [7:0]         master_clear_i,
  input  wire lut_pkg::fe_req_t   fe_req_i,
  output lut_pkg::fe_ans_t        fe_ans_o,
  input  wire lut_pkg::be_req_t   be_req_i,
  output lut_pkg::be_ans_t        be_ans_o
);

  // host register state
  logic        wait_q,     wait_d;
  logic [31:0] rdata_q,    rdata_d;
  logic [3:0]  selector_q, selector_d;
  logic [14:0] start_q,    start_d;
  logic [14:0] index_q,    index_d;
  logic [1:0]  pending_q,  pending_d;
  logic [1:0]  bank_q,     bank_d;
  logic [14:0] dl_addr;
  logic        dl_write;

  // bus slave: one idle cycle with waitrequest high, then one answer cycle
  always_comb begin
    wait_d     = 1'b1;
    rdata_d    = rdata_q;
    selector_d = selector_q;
    start_d    = start_q;
    index_d    = index_q;
    pending_d  = pending_q;
    bank_d     = bank_q;
    dl_write   = 1'b0;
    if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_d = 1'b0;
      rdata_d = 32'h0000_0000;
      if (avs_read_i) begin
        case (avs_address_i)
          lut_pkg::OFS_SELECTOR: rdata_d = {28'h000_0000, selector_q};
          lut_pkg::OFS_START:    rdata_d = {17'h0_0000, start_q};
          lut_pkg::OFS_DATA:     rdata_d = {17'h0_0000, index_q};
          lut_pkg::OFS_BANK:     rdata_d = {28'h000_0000, bank_q, pending_q};
          lut_pkg::OFS_STATUS:   rdata_d = {17'h0_0000, dl_addr};
          default:               rdata_d = 32'h0000_0000;
        endcase
      end
    end
    if (avs_write_i && !wait_q) begin
      case (avs_address_i)
        lut_pkg::OFS_SELECTOR: selector_d = avs_writedata_i[3:0];
        lut_pkg::OFS_START: begin
          start_d = avs_writedata_i[14:0];
          index_d = 15'h0000;
        end
        lut_pkg::OFS_DATA: begin
          dl_write = 1'b1;                                  // see (RQ23)
          index_d  = 15'(index_q + 15'h0001);                // see (RQ24)
        end
        lut_pkg::OFS_BANK:     pending_d = avs_writedata_i[1:0];
        default: ;
      endcase
    end
    // a new bank only takes hold at the next interval tick
    if (interval_tick_i) begin
      bank_d = (avs_write_i && !wait_q && avs_address_i == lut_pkg::OFS_BANK)
               ? avs_writedata_i[1:0] : pending_q;         // see (RQ16)
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      wait_q     <= 1'b1;
      rdata_q    <= 32'h0000_0000;
      selector_q <= lut_pkg::RST_SELECTOR;
      start_q    <= lut_pkg::RST_START;
      index_q    <= 15'h0000;
      pending_q  <= lut_pkg::RST_BANK;
      bank_q     <= lut_pkg::RST_BANK;
    end else begin
      wait_q     <= wait_d;
      rdata_q    <= rdata_d;
      selector_q <= selector_d;
      start_q    <= start_d;
      index_q    <= index_d;
      pending_q  <= pending_d;
      bank_q     <= bank_d;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;
  assign dl_addr           = 15'(start_q + index_q);          // see (RQ24)

  // per-table write enables from the selector code
  logic [8:0] table_we;
  always_comb begin
    table_we = 9'h000;
    if (dl_write && selector_q <= lut_pkg::SEL_BE_VAL_ACC) begin
      table_we[selector_q] = 1'b1;                         // see (RQ24)
    end
  end

  // pipeline state
  lut_pkg::fe_req_t fe_s1_q, fe_s1_d;
  lut_pkg::fe_req_t fe_s2_q, fe_s2_d;
  lut_pkg::be_req_t be_s1_q, be_s1_d;
  lut_pkg::be_req_t be_s2_q, be_s2_d;
  logic [7:0]       fe_base_s2_q, fe_base_s2_d;
  logic [7:0]       fe_map_s2_q,  fe_map_s2_d;
  logic [7:0]       be_map_s2_q,  be_map_s2_d;
  lut_pkg::fe_ans_t fe_ans_q, fe_ans_d;
  lut_pkg::be_ans_t be_ans_q, be_ans_d;

  // table read data
  logic [7:0] fe_base_rd, fe_map_rd, fe_val_rd, fe_low_rd, fe_high_rd;
  logic [7:0] be_map_rd, be_val_rd, be_low_rd, be_high_rd;

  // table read addresses
  logic [lut_pkg::BANKED_ADDR_W-1:0]   fe_bl_addr, be_bl_addr;
  logic [lut_pkg::VALIDITY_ADDR_W-1:0] fe_val_addr, be_val_addr;
  logic [lut_pkg::RESULT_ADDR_W-1:0]   fe_res_addr, be_res_addr;
  logic [3:0]                          fe_map, be_map;

  always_comb begin
    fe_bl_addr  = {bank_q, fe_req_i.hardware_baseline};    // see (RQ15) (RQ19)
    be_bl_addr  = {bank_q, be_req_i.hardware_baseline};    // see (RQ19)
    fe_map      = fe_map_rd[3:0];                          // see (RQ21)
    be_map      = be_map_rd[3:0];                          // see (RQ21)
    fe_res_addr = {fe_map, fe_s1_q.array, fe_s1_q.spectral}; // see (RQ6) (RQ14)
    be_res_addr = {be_map, be_s1_q.result};                // see (RQ6) (RQ8)
    // tape validities index by baseline, pulsar by spectral result
    fe_val_addr = {bank_q, fe_map[0],
                   fe_map[0] ? fe_s1_q.spectral : fe_s1_q.hardware_baseline}; // see (RQ5)
    be_val_addr = {bank_q, be_map[0],
                   be_map[0] ? be_s1_q.result[7:0] : be_s1_q.hardware_baseline}; // see (RQ5)
  end

  // front-end stage two and answer
  always_comb begin
    logic [2:0] acc;
    acc          = 3'h0;
    fe_s1_d      = fe_req_i;
    fe_s2_d      = fe_s1_q;
    fe_base_s2_d = fe_base_rd;
    fe_map_s2_d  = fe_map_rd;
    fe_ans_d     = '0;
    // validity maps take the accumulation time from the validity table
    acc = fe_map_s2_q[lut_pkg::VALIDITY_BIT] ? fe_val_rd[2:0]
        : fe_map_s2_q[lut_pkg::ACCUM_CODE_LSB +: lut_pkg::ACCUM_W]; // see (RQ3) (RQ4) (RQ22)
    // baselines past the last hardware source carry no data
    fe_ans_d.valid = fe_s2_q.valid
                     && fe_s2_q.hardware_baseline <= lut_pkg::LAST_BASELINE; // see (RQ18)
    fe_ans_d.accum_baseline = fe_base_s2_q;                // see (RQ15)
    fe_ans_d.result = {fe_high_rd[lut_pkg::HIGH_RESULT_W-1:0], fe_low_rd}; // see (RQ10) (RQ11)
    fe_ans_d.accum_time = acc;
    fe_ans_d.clear_accumulator = fe_ans_d.valid && master_clear_i[acc]
                                 && !fe_high_rd[lut_pkg::INHIBIT_BIT]; // see (RQ12)
  end

  // back-end stage two and answer
  always_comb begin
    be_s1_d     = be_req_i;
    be_s2_d     = be_s1_q;
    be_map_s2_d = be_map_rd;
    be_ans_d    = '0;
    be_ans_d.valid = be_s2_q.valid
                     && be_s2_q.hardware_baseline <= lut_pkg::LAST_BASELINE; // see (RQ18)
    // only the three low bits of the high byte count
    be_ans_d.result_pointer = {be_high_rd[lut_pkg::HIGH_RESULT_W-1:0], be_low_rd}; // see (RQ2) (RQ7)
    be_ans_d.accum_time = be_map_s2_q[lut_pkg::VALIDITY_BIT] ? be_val_rd[2:0]
        : be_map_s2_q[lut_pkg::ACCUM_CODE_LSB +: lut_pkg::ACCUM_W]; // see (RQ4) (RQ22)
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      fe_s1_q      <= '0;
      fe_s2_q      <= '0;
      be_s1_q      <= '0;
      be_s2_q      <= '0;
      fe_base_s2_q <= 8'h00;
      fe_map_s2_q  <= 8'h00;
      be_map_s2_q  <= 8'h00;
      fe_ans_q     <= '0;
      be_ans_q     <= '0;
    end else begin
      fe_s1_q      <= fe_s1_d;
      fe_s2_q      <= fe_s2_d;
      be_s1_q      <= be_s1_d;
      be_s2_q      <= be_s2_d;
      fe_base_s2_q <= fe_base_s2_d;
      fe_map_s2_q  <= fe_map_s2_d;
      be_map_s2_q  <= be_map_s2_d;
      fe_ans_q     <= fe_ans_d;
      be_ans_q     <= be_ans_d;
    end
  end

  assign fe_ans_o = fe_ans_q;
  assign be_ans_o = be_ans_q;

  // table RAMs: written only from the download path
  table_ram #(.ADDR_W(lut_pkg::RESULT_ADDR_W), .DATA_W(8)) backend_result_low_table (
    .clock_i   (clock_i),
    .wr_en_i   (table_we[lut_pkg::SEL_BE_LOW]),
    .wr_addr_i (dl_addr),
    .wr_data_i (avs_writedata_i[7:0]),
    .rd_addr_i (be_res_addr),
    .rd_data_o (be_low_rd)
  );

  table_ram #(.ADDR_W(lut_pkg::RESULT_ADDR_W), .DATA_W(8)) backend_result_high_table (
    .clock_i   (clock_i),
    .wr_en_i   (table_we[lut_pkg::SEL_BE_HIGH]),
    .wr_addr_i (dl_addr),
    .wr_data_i (avs_writedata_i[7:0]),
    .rd_addr_i (be_res_addr),
    .rd_data_o (be_high_rd)
  );

  table_ram #(.ADDR_W(lut_pkg::RESULT_ADDR_W), .DATA_W(8)) frontend_result_low_table (
    .clock_i   (clock_i),
    .wr_en_i   (table_we[lut_pkg::SEL_FE_LOW]),
    .wr_addr_i (dl_addr),
    .wr_data_i (avs_writedata_i[7:0]),
    .rd_addr_i (fe_res_addr),
    .rd_data_o (fe_low_rd)
  );

  table_ram #(.ADDR_W(lut_pkg::RESULT_ADDR_W), .DATA_W(8)) frontend_result_high_table (
    .clock_i   (clock_i),
    .wr_en_i   (table_we[lut_pkg::SEL_FE_HIGH]),
    .wr_addr_i (dl_addr),
    .wr_data_i (avs_writedata_i[7:0]),
    .rd_addr_i (fe_res_addr),
    .rd_data_o (fe_high_rd)
  );

  table_ram #(.ADDR_W(lut_pkg::BANKED_ADDR_W), .DATA_W(8)) frontend_baseline_table (
    .clock_i   (clock_i),
    .wr_en_i   (table_we[lut_pkg::SEL_FE_BASELINE]),
    .wr_addr_i (dl_addr[lut_pkg::BANKED_ADDR_W-1:0]),
    .wr_data_i (avs_writedata_i[7:0]),
    .rd_addr_i (fe_bl_addr),
    .rd_data_o (fe_base_rd)
  );

  table_ram #(.ADDR_W(lut_pkg::BANKED_ADDR_W), .DATA_W(8)) frontend_accum_map_table (
    .clock_i   (clock_i),
    .wr_en_i   (table_we[lut_pkg::SEL_FE_ACC_MAP]),
    .wr_addr_i (dl_addr[lut_pkg::BANKED_ADDR_W-1:0]),
    .wr_data_i (avs_writedata_i[7:0]),
    .rd_addr_i (fe_bl_addr),
    .rd_data_o (fe_map_rd)
  );

  table_ram #(.ADDR_W(lut_pkg::VALIDITY_ADDR_W), .DATA_W(8)) frontend_validity_accum_table (
    .clock_i   (clock_i),
    .wr_en_i   (table_we[lut_pkg::SEL_FE_VAL_ACC]),
    .wr_addr_i (dl_addr[lut_pkg::VALIDITY_ADDR_W-1:0]),
    .wr_data_i (avs_writedata_i[7:0]),
    .rd_addr_i (fe_val_addr),
    .rd_data_o (fe_val_rd)
  );

  table_ram #(.ADDR_W(lut_pkg::BANKED_ADDR_W), .DATA_W(8)) backend_accum_map_table (
    .clock_i   (clock_i),
    .wr_en_i   (table_we[lut_pkg::SEL_BE_ACC_MAP]),
    .wr_addr_i (dl_addr[lut_pkg::BANKED_ADDR_W-1:0]),
    .wr_data_i (avs_writedata_i[7:0]),
    .rd_addr_i (be_bl_addr),
    .rd_data_o (be_map_rd)
  );

  table_ram #(.ADDR_W(lut_pkg::VALIDITY_ADDR_W), .DATA_W(8)) backend_validity_accum_table (
    .clock_i   (clock_i),
    .wr_en_i   (table_we[lut_pkg::SEL_BE_VAL_ACC]),
    .wr_addr_i (dl_addr[lut_pkg::VALIDITY_ADDR_W-1:0]),
    .wr_data_i (avs_writedata_i[7:0]),
    .rd_addr_i (be_val_addr),
    .rd_data_o (be_val_rd)
  );

endmodule

// File: lut_pkg.sv
// Purpose: shared constants and carriers for the accumulator lookup tables
// Assumes: 40 MHz system clock, byte-wide table downloads from the host
// Notes:   byte offsets of the Avalon registers are word aligned
package lut_pkg;

  // table geometry
  localparam int RESULT_ADDR_W   = 15;
  localparam int BANKED_ADDR_W   = 10;
  localparam int VALIDITY_ADDR_W = 11;
  localparam int BYTE_W          = 8;
  localparam int RESULT_W        = 11;
  localparam int MAP_W           = 4;
  localparam int ACCUM_W         = 3;
  localparam int BANK_W          = 2;

  // field positions inside table bytes
  localparam int ACCUM_CODE_LSB  = 4;
  localparam int HIGH_RESULT_W   = 3;
  localparam int INHIBIT_BIT     = 7;
  localparam int VALIDITY_BIT    = 3;

  localparam logic [7:0] LAST_BASELINE = 8'hD7;

  // host selector codes for the download path
  localparam logic [3:0] SEL_BE_LOW      = 4'h0;
  localparam logic [3:0] SEL_BE_HIGH     = 4'h1;
  localparam logic [3:0] SEL_FE_LOW      = 4'h2;
  localparam logic [3:0] SEL_FE_HIGH     = 4'h3;
  localparam logic [3:0] SEL_FE_BASELINE = 4'h4;
  localparam logic [3:0] SEL_FE_ACC_MAP  = 4'h5;
  localparam logic [3:0] SEL_FE_VAL_ACC  = 4'h6;
  localparam logic [3:0] SEL_BE_ACC_MAP  = 4'h7;
  localparam logic [3:0] SEL_BE_VAL_ACC  = 4'h8;

  // Avalon register byte offsets
  localparam logic [4:0] OFS_SELECTOR = 5'h00;
  localparam logic [4:0] OFS_START    = 5'h04;
  localparam logic [4:0] OFS_DATA     = 5'h08;
  localparam logic [4:0] OFS_BANK     = 5'h0C;
  localparam logic [4:0] OFS_STATUS   = 5'h10;

  // reset values
  localparam logic [3:0]  RST_SELECTOR = 4'h0;
  localparam logic [14:0] RST_START    = 15'h0000;
  localparam logic [1:0]  RST_BANK     = 2'h0;

  typedef struct packed {
    logic       valid;
    logic [7:0] hardware_baseline;
    logic [2:0] array;
    logic [7:0] spectral;
  } fe_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  accum_baseline;
    logic [10:0] result;
    logic [2:0]  accum_time;
    logic        clear_accumulator;
  } fe_ans_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  hardware_baseline;
    logic [10:0] result;
  } be_req_t;

  typedef struct packed {
    logic        valid;
    logic [10:0] result_pointer;
    logic [2:0]  accum_time;
  } be_ans_t;

endpackage

// File: table_ram.sv
// Purpose: one lookup table RAM, host write port and datapath read port
// Assumes: single clock, no reset on contents
// Notes:   read data come out of a register, one cycle after the address
`timescale 1ns/1ps
module table_ram #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 8
) (
  input  wire logic              clock_i,
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [DATA_W-1:0] rd_data_o
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule

// File: lut_checker.sv
// Purpose: concurrent checks on the lookup table ports
// Assumes: an answer stands three edges after its request edge
// Notes:   table contents and banks are not visible here, so only timing and gating
`timescale 1ns/1ps
module lut_checker (
  input wire logic             clock_i,
  input wire logic             reset_n_i,
  input wire logic             avs_read_i,
  input wire logic             avs_write_i,
  input wire logic             avs_waitrequest_o,
  input wire logic [7:0]       master_clear_i,
  input wire lut_pkg::fe_req_t fe_req_i,
  input wire lut_pkg::fe_ans_t fe_ans_o,
  input wire lut_pkg::be_req_t be_req_i,
  input wire lut_pkg::be_ans_t be_ans_o
);
  logic [7:0] clear_d;
  logic [7:0] clear_q;
  always_comb clear_d = master_clear_i;
  always_ff @(posedge clock_i) clear_q <= clear_d;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  property p_accept;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_accept: assert property (p_accept) else $error("access not answered");
  property p_one_low;
    $fell(avs_waitrequest_o) |=> avs_waitrequest_o;
  endproperty
  a_one_low: assert property (p_one_low) else $error("waitrequest low too long");
  property p_fe_refuse;
    fe_req_i.valid && fe_req_i.hardware_baseline > lut_pkg::LAST_BASELINE
      |-> ##3 !fe_ans_o.valid && !fe_ans_o.clear_accumulator;
  endproperty
  a_fe_refuse: assert property (p_fe_refuse) else $error("ignored baseline answered");
  property p_fe_pass;
    fe_req_i.valid && fe_req_i.hardware_baseline <= lut_pkg::LAST_BASELINE |-> ##3 fe_ans_o.valid;
  endproperty
  a_fe_pass: assert property (p_fe_pass) else $error("front lookup lost");
  property p_fe_idle;
    !fe_req_i.valid |-> ##3 !fe_ans_o.valid && !fe_ans_o.clear_accumulator;
  endproperty
  a_fe_idle: assert property (p_fe_idle) else $error("front answer without request");
  property p_be_pass;
    be_req_i.valid && be_req_i.hardware_baseline <= lut_pkg::LAST_BASELINE |-> ##3 be_ans_o.valid;
  endproperty
  a_be_pass: assert property (p_be_pass) else $error("back lookup lost");
  property p_be_idle;
    !be_req_i.valid |-> ##3 !be_ans_o.valid;
  endproperty
  a_be_idle: assert property (p_be_idle) else $error("back answer without request");
  property p_clear;
    fe_ans_o.clear_accumulator |-> fe_ans_o.valid && clear_q[fe_ans_o.accum_time];
  endproperty
  a_clear: assert property (p_clear) else $error("clear without master clear");
  c_refuse: cover property (fe_req_i.valid && fe_req_i.hardware_baseline > 8'hD7);
  c_clear: cover property (fe_ans_o.clear_accumulator);
  c_write: cover property (avs_write_i && !avs_waitrequest_o);
endmodule

bind accumulator_lookup_tables lut_checker chk (
  .clock_i           (clock_i),
  .reset_n_i         (reset_n_i),
  .avs_read_i        (avs_read_i),
  .avs_write_i       (avs_write_i),
  .avs_waitrequest_o (avs_waitrequest_o),
  .master_clear_i    (master_clear_i),
  .fe_req_i          (fe_req_i),
  .fe_ans_o          (fe_ans_o),
  .be_req_i          (be_req_i),
  .be_ans_o          (be_ans_o)
);

// File: host_bus_model.sv
// Purpose: Avalon-MM host that reads registers and downloads table blocks
// Assumes: slave answers through waitrequest, sampled on the rising edge
// Notes:   one request at a time; released only after the accepting edge
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic        clock_i,
  input  wire logic        waitrequest_i,
  input  wire logic [31:0] readdata_i,
  output logic      [4:0]  address_o,
  output logic             read_o,
  output logic             write_o,
  output logic      [31:0] writedata_o
);
  initial begin
    address_o = 5'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
  end
  task automatic access(input logic [4:0] a, input logic rd, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge clock_i);
    address_o <= a;
    read_o <= rd;
    write_o <= !rd;
    writedata_o <= d;
    // iff sees waitrequest as it stood at the edge, before the slave updates it
    @(posedge clock_i iff !waitrequest_i);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
  endtask
  task automatic block(input logic [3:0] sel, input logic [14:0] start,
                       input logic [7:0] d [256]);
    logic [31:0] q;
    access(lut_pkg::OFS_SELECTOR, 1'b0, {28'h0, sel}, q);
    access(lut_pkg::OFS_START, 1'b0, {17'h0, start}, q);
    for (int i = 0; i < 256; i++) begin
      access(lut_pkg::OFS_DATA, 1'b0, {24'h0, d[i]}, q);
    end
  endtask
endmodule

// File: accumulator_lookup_tables_test.sv
// Purpose: self-checking bench for the accumulator lookup tables
// Assumes: answers stand three cycles after the request cycle
// Notes:   only maps 0, 1, 8, 9 and arrays 0-1 are loaded, to keep downloads short
`timescale 1ns/1ps
module accumulator_lookup_tables_test;
  logic             clock_i = 1'b0;
  logic             reset_n_i = 1'b0;
  logic             interval_tick_i = 1'b0;
  logic [7:0]       master_clear_i = 8'h00;
  lut_pkg::fe_req_t fe_req_i = '0;
  lut_pkg::be_req_t be_req_i = '0;
  lut_pkg::fe_ans_t fe_ans_o;
  lut_pkg::be_ans_t be_ans_o;
  logic [4:0]       avs_address;
  logic             avs_read;
  logic             avs_write;
  logic             avs_waitrequest;
  logic [31:0]      avs_writedata;
  logic [31:0]      avs_readdata;
  logic [31:0]      q;
  int               fails = 0;
  int               compares = 0;
  int unsigned      seed = 42;
  logic [7:0]       mem [int];

  initial begin
    forever #12.5 clock_i = ~clock_i;
  end

  accumulator_lookup_tables uut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
    .interval_tick_i(interval_tick_i), .master_clear_i(master_clear_i),
    .fe_req_i(fe_req_i), .fe_ans_o(fe_ans_o), .be_req_i(be_req_i), .be_ans_o(be_ans_o));
  host_bus_model host (
    .clock_i(clock_i), .waitrequest_i(avs_waitrequest), .readdata_i(avs_readdata),
    .address_o(avs_address), .read_o(avs_read), .write_o(avs_write),
    .writedata_o(avs_writedata));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] t(input int s, input int a);
    return mem.exists((s << 16) | a) ? mem[(s << 16) | a] : 8'hXX;
  endfunction
  function automatic lut_pkg::fe_ans_t fe_exp(input lut_pkg::fe_req_t r,
                                              input logic [7:0] mc, input logic [1:0] b);
    lut_pkg::fe_ans_t e;
    logic [7:0]       m, hi, v;
    logic [14:0]      ra;
    m = t(5, {b, r.hardware_baseline});
    ra = {m[3:0], r.array, r.spectral};
    hi = t(3, ra);
    v = t(6, {b, m[0], m[0] ? r.spectral : r.hardware_baseline});
    e.valid = r.valid && r.hardware_baseline <= lut_pkg::LAST_BASELINE;
    e.accum_baseline = t(4, {b, r.hardware_baseline});
    e.result = {hi[2:0], t(2, ra)};
    e.accum_time = m[3] ? v[2:0] : m[6:4];
    e.clear_accumulator = e.valid && mc[e.accum_time] && !hi[7];
    return e;
  endfunction
  function automatic lut_pkg::be_ans_t be_exp(input lut_pkg::be_req_t r, input logic [1:0] b);
    lut_pkg::be_ans_t e;
    logic [7:0]       m, hi, v;
    logic [14:0]      ra;
    m = t(7, {b, r.hardware_baseline});
    ra = {m[3:0], r.result};
    hi = t(1, ra);
    v = t(8, {b, m[0], m[0] ? r.result[7:0] : r.hardware_baseline});
    e.valid = r.valid;
    e.result_pointer = {hi[2:0], t(0, ra)};
    e.accum_time = m[3] ? v[2:0] : m[6:4];
    return e;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task rd(input logic [4:0] a, input logic [31:0] exp, input string what);
    host.access(a, 1'b1, 32'h0, q);
    chk(q, exp, what);
  endtask
  task load(input int s, input int st);
    logic [7:0] d [256];
    logic [7:0] k;
    k = 8'(rnd());
    for (int i = 0; i < 256; i++) begin
      d[i] = 8'(rnd());
      // map codes kept to 0, 1, 8, 9 so only loaded result blocks are reached
      if (s == 5 || s == 7) d[i] = d[i] & 8'hF9;
      if (s == 4 && i < 216) d[i] = i < 210 ? 8'(d[i] % 210) : 8'(i);
      // back-end maps stay one-to-one per map; the five upper bits stay random
      if (s == 0) d[i] = 8'(i ^ (st >> 11));
      if (s == 1) d[i] = {d[i][7:3], 3'((st >> 8) ^ (st >> 11))};
      // array 1 reduces onto array 0, so only the later copy inhibits the clear
      if (s == 2) d[i] = st[8] ? mem[(2 << 16) | (st - 256 + i)] : 8'(i) ^ k;
      if (s == 3) d[i] = st[8] ? mem[(3 << 16) | (st - 256 + i)] | 8'h80 : d[i] & 8'h7F;
      mem[(s << 16) | (st + i)] = d[i];
    end
    host.block(4'(s), 15'(st), d);
  endtask
  task run(input int n, input logic [1:0] b);
    lut_pkg::fe_req_t f, fr [int];
    lut_pkg::be_req_t g, br [int];
    lut_pkg::fe_ans_t e, fx [int];
    lut_pkg::be_ans_t h, bx [int];
    logic [7:0]       mc;
    for (int j = 0; j < n + 3; j++) begin
      @(posedge clock_i);
      f = '0;
      g = '0;
      if (j < n) begin
        f.valid = j < 4 || rnd() % 4 != 0;
        f.hardware_baseline = j < 4 ? 8'hD5 + 8'(j) : 8'(rnd());
        f.array = 3'(rnd() % 2);
        f.spectral = 8'(rnd());
        g.valid = rnd() % 4 != 0;
        g.hardware_baseline = 8'(rnd() % 216);
        g.result = {3'(rnd() % 2), 8'(rnd())};
      end
      mc = 8'(rnd());
      fe_req_i <= f;
      be_req_i <= g;
      master_clear_i <= mc;
      fr[j] = f;
      br[j] = g;
      if (j >= 2) fx[j - 2] = fe_exp(fr[j - 2], mc, b);
      if (j >= 2) bx[j - 2] = be_exp(br[j - 2], b);
      #1;
      if (j >= 3) begin
        e = fx[j - 3];
        h = bx[j - 3];
        chk(e.valid ? 32'(fe_ans_o) : 32'({fe_ans_o.valid, fe_ans_o.clear_accumulator}),
            e.valid ? 32'(e) : 32'h0, "front answer");
        chk(h.valid ? 32'(be_ans_o) : 32'(be_ans_o.valid),
            h.valid ? 32'(h) : 32'h0, "back answer");
      end
    end
  endtask

  task report_and_stop();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rd(lut_pkg::OFS_SELECTOR, 32'h0, "selector reset");
    rd(lut_pkg::OFS_START, 32'h0, "start reset");
    rd(lut_pkg::OFS_BANK, 32'h0, "bank reset");
    host.access(5'h14, 1'b0, 32'hFFFFFFFF, q);
    rd(5'h14, 32'h0, "unmapped");
    host.access(lut_pkg::OFS_START, 1'b0, 32'h1234, q);
    rd(lut_pkg::OFS_STATUS, 32'h1234, "start address");
    host.access(lut_pkg::OFS_DATA, 1'b0, 32'h5A, q);
    rd(lut_pkg::OFS_STATUS, 32'h1235, "next address");
    rd(lut_pkg::OFS_DATA, 32'h1, "byte index");
    for (int b = 0; b < 2; b++) begin
      load(4, b << 8);
      load(5, b << 8);
      load(7, b << 8);
      for (int v = 0; v < 2; v++) load(6, (b << 9) | (v << 8));
      for (int v = 0; v < 2; v++) load(8, (b << 9) | (v << 8));
    end
    for (int k = 0; k < 32; k++) begin
      load(k % 4, ((k >> 4) << 14) | (((k >> 3) % 2) << 11) | (((k >> 2) % 2) << 8));
    end
    run(300, 2'd0);
    host.access(lut_pkg::OFS_BANK, 1'b0, 32'h1, q);
    rd(lut_pkg::OFS_BANK, 32'h1, "pending bank");
    run(20, 2'd0);
    @(posedge clock_i);
    interval_tick_i <= 1'b1;
    @(posedge clock_i);
    interval_tick_i <= 1'b0;
    rd(lut_pkg::OFS_BANK, 32'h5, "active bank");
    run(300, 2'd1);
    report_and_stop();
  end

  initial begin
    #1500000;
    fails++;
    report_and_stop();
  end
endmodule
